// ==== pbad_cfg.svh ====
`ifndef PBAD_CFG_SVH
`define PBAD_CFG_SVH

// Region bases, from the top address nibble
`define PBAD_RGN_BOOT 4'h0
`define PBAD_RGN_GLUE 4'h1
`define PBAD_RGN_PCI 4'h2
`define PBAD_RGN_ONCHIP 4'h3
`define PBAD_RGN_SDRAM 4'h4
`define PBAD_RGN_SRAM 4'h5
`define PBAD_RGN_ZBUS 4'h6
`define PBAD_RGN_RSVD 4'h7
// Populated sizes, as address widths
`define PBAD_FLASH_AW 16
`define PBAD_SDRAM_AW 25
`define PBAD_SRAM_AW 12
`define PBAD_WIN_AW 12
// Communications-bus window plan
`define PBAD_NUM_SERIAL 8
`define PBAD_WIN_LINEDRV 8
`define PBAD_WIN_TESTIN 9
`define PBAD_WIN_BOARDID 10
`define PBAD_NUM_WIN 11
`define PBAD_ZBUS_DATA_CYC 4'h4
// Glue-logic register offsets
`define PBAD_GLUE_USEC 12'h000
`define PBAD_GLUE_STATUS 12'h004
// PCI interface doorbell offsets and initiator commands
`define PBAD_PCI_DBELL_HOST 28'h000_0060
`define PBAD_PCI_DBELL_LOCAL 28'h000_0064
`define PBAD_PCI_CMD_MEMRD 4'h6
`define PBAD_PCI_CMD_MEMWR 4'h7
// Power-up configuration byte fields
`define PBAD_CFG_AW32 8'h01
`define PBAD_CFG_MULT4 8'h08
`define PBAD_CFG_BYTE (`PBAD_CFG_AW32 | `PBAD_CFG_MULT4)
// Clocking
`define PBAD_CLK_PERIOD_NS 8
`define PBAD_CLK_MHZ 125
`define PBAD_BUS_CLK_MHZ 40
`define PBAD_CORE_MULT 4
`define PBAD_CORE_MHZ (`PBAD_BUS_CLK_MHZ * `PBAD_CORE_MULT)
`define PBAD_USEC_NS 1000
`define PBAD_USEC_CYC (`PBAD_USEC_NS / `PBAD_CLK_PERIOD_NS)

`endif

// ==== pbad_cnt_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pbad_cnt_if;
  logic [31:0] count;
  logic tick;
  modport counter (output count, output tick);
  modport user (input count, input tick);
endinterface
`default_nettype wire

// ==== pbad_decoder.sv ====
// What this block does
// - Primary bus: separate 32-bit address, data
// - Comm bus multiplexes address, data on 16
// - Region 0: flash in lowest 64 KB
// - Region 1 decodes to glue logic
// - Glue exposes 32-bit one-megahertz counter
// - Region 2 routes to PCI interface
// - Region 3 claimed by on-chip peripherals
// - Region 4 selects SDRAM, 32 MB populated
// - Region 5 maps internal 4 KB SRAM
// - Region 6: comm bus, 4 KB windows
// - Windows: serial, line-driver, test, board ID
// - Region 7 unassigned, reserved
// - Upper 2 GB pass to PCI memory
// - PCI initiator: memory read/write only
// - Two doorbells: host and local interrupts
// - Module registers: 4 KB block, 4 KB steps
// - Core 160 MHz, four times bus clock
`timescale 1ns/1ns
`default_nettype none
`include "pbad_cfg.svh"
module pbad_decoder
  import pbad_pkg::*;
#(
  parameter int NUM_WIN = `PBAD_NUM_WIN,
  parameter logic [3:0] ZDATA_CYC = `PBAD_ZBUS_DATA_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Primary bus from the processor
  input wire logic I_TS,
  input wire logic [31:0] I_ADDR,
  input wire logic I_RW,
  input wire logic [31:0] I_WDATA,
  input wire logic [19:0] I_MODULE_BASE,
  input wire logic I_TGT_ACK,
  output logic [31:0] O_RDATA,
  output logic O_RDATA_OE,
  output logic O_TA,
  output logic O_TEA,
  // Target selects
  output logic O_BOOT_SEL,
  output logic O_GLUE_SEL,
  output logic O_PCI_SEL,
  output logic O_PCI_DIRECT_SEL,
  output logic [3:0] O_PCI_CMD,
  output logic [1:0] O_PCI_DBELL_SEL,
  output logic O_ONCHIP_SEL,
  output logic O_MODULE_SEL,
  output logic O_SDRAM_SEL,
  output logic O_SRAM_SEL,
  output logic [NUM_WIN-1:0] O_ZWIN_SEL,
  // Communications bus
  input wire logic [15:0] I_ZAD,
  output logic [15:0] O_ZAD,
  output logic O_ZAD_OE,
  output logic O_ZAS_N,
  output logic O_ZDS_N,
  output logic O_ZRW
);
  logic busy_reg;
  logic [31:0] addr_reg;
  logic rw_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic ta_reg;
  logic tea_reg;
  logic cfg_oe_reg;
  logic [31:0] err_addr_reg;
  pbad_zstate_t zst_reg;
  logic [3:0] zcnt_reg;
  logic [15:0] zad_reg;
  logic zad_oe_reg;
  logic zas_n_reg;
  logic zds_n_reg;
  logic [3:0] rgn;
  logic hit_boot, hit_glue, hit_pci, hit_onchip, hit_sdram, hit_sram, hit_zbus, hit_direct;
  logic [15:0] win_idx;
  logic win_ok;
  logic err_hit;
  logic int_done;
  logic [NUM_WIN-1:0] win_dec;

  pbad_cnt_if cnt ();

  pbad_usec_counter #(
    .DIV(`PBAD_USEC_CYC)
  ) u_usec (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .cnt(cnt.counter)
  );

  // address and data latched as full words
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_reg <= 32'h0000_0000;
      rw_reg <= 1'b1;
      wdata_reg <= 32'h0000_0000;
    end else if (I_TS && !busy_reg) begin
      addr_reg <= I_ADDR;
      rw_reg <= I_RW;
      wdata_reg <= I_WDATA;
    end
  end

  assign rgn = addr_reg[31:28];
  assign win_idx = addr_reg[27:12];
  // windows past the board ID are not decoded and end in a bus error
  assign win_ok = (win_idx < 16'(NUM_WIN));

  // flash only in lowest 64 KB
  assign hit_boot = (rgn == `PBAD_RGN_BOOT) && (addr_reg[27:`PBAD_FLASH_AW] == '0);
  assign hit_glue = (rgn == `PBAD_RGN_GLUE) && (addr_reg[27:12] == '0);
  assign hit_pci = (rgn == `PBAD_RGN_PCI);
  assign hit_onchip = (rgn == `PBAD_RGN_ONCHIP);
  assign hit_sdram = (rgn == `PBAD_RGN_SDRAM) && (addr_reg[27:`PBAD_SDRAM_AW] == '0);
  assign hit_sram = (rgn == `PBAD_RGN_SRAM) && (addr_reg[27:`PBAD_SRAM_AW] == '0);
  // comm bus region, one window per device
  assign hit_zbus = (rgn == `PBAD_RGN_ZBUS) && win_ok;
  // upper half passes to PCI memory
  assign hit_direct = addr_reg[31];
  // everything else terminates with a bus error
  assign err_hit = !(hit_boot || hit_glue || hit_pci || hit_onchip || hit_sdram
                     || hit_sram || hit_zbus || hit_direct);

  genvar w;
  generate
    for (w = 0; w < NUM_WIN; w++) begin : g_win
      assign win_dec[w] = (win_idx == 16'(w));
    end
  endgenerate

  assign O_BOOT_SEL = busy_reg && hit_boot;
  assign O_GLUE_SEL = busy_reg && hit_glue;
  assign O_PCI_SEL = busy_reg && hit_pci;
  assign O_PCI_DIRECT_SEL = busy_reg && hit_direct;
  assign O_ONCHIP_SEL = busy_reg && hit_onchip;
  // module block matched on 4 KB boundary
  assign O_MODULE_SEL = busy_reg && (addr_reg[31:12] == I_MODULE_BASE);
  assign O_SDRAM_SEL = busy_reg && hit_sdram;
  assign O_SRAM_SEL = busy_reg && hit_sram;
  assign O_ZWIN_SEL = (busy_reg && hit_zbus) ? win_dec : '0;

  // doorbells toward host and local processor
  assign O_PCI_DBELL_SEL[0] = O_PCI_SEL && (addr_reg[27:0] == `PBAD_PCI_DBELL_HOST);
  assign O_PCI_DBELL_SEL[1] = O_PCI_SEL && (addr_reg[27:0] == `PBAD_PCI_DBELL_LOCAL);

  assign O_PCI_CMD = rw_reg ? `PBAD_PCI_CMD_MEMRD : `PBAD_PCI_CMD_MEMWR;

  // Glue and error accesses end one cycle in; comm bus ends from its sequencer
  assign int_done = busy_reg && !ta_reg && !tea_reg
                    && ((hit_glue && !cfg_oe_reg) || err_hit || (zst_reg == PBAD_Z_DONE));

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_reg <= 1'b0;
    end else if (I_TS && !busy_reg) begin
      busy_reg <= 1'b1;
    end else if (int_done || (I_TGT_ACK && !hit_glue && !hit_zbus && !err_hit)) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ta_reg <= 1'b0;
      tea_reg <= 1'b0;
    end else begin
      ta_reg <= int_done && !err_hit;
      tea_reg <= int_done && err_hit;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      err_addr_reg <= 32'h0000_0000;
    end else if (int_done && err_hit) begin
      err_addr_reg <= addr_reg;
    end
  end

  // counter and bus status readable in glue space
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (int_done && hit_glue) begin
      case (addr_reg[11:0])
        `PBAD_GLUE_USEC: rdata_reg <= cnt.count;
        `PBAD_GLUE_STATUS: rdata_reg <= err_addr_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (zst_reg == PBAD_Z_DATA && rw_reg && zcnt_reg == 4'h0) begin
      rdata_reg <= {16'h0000, I_ZAD};
    end
  end

  // config byte driven through reset release
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_oe_reg <= 1'b1;
    end else begin
      cfg_oe_reg <= 1'b0;
    end
  end

  assign O_RDATA = cfg_oe_reg ? {24'h00_0000, 8'(`PBAD_CFG_BYTE)} : rdata_reg;
  assign O_RDATA_OE = cfg_oe_reg || (ta_reg && rw_reg);
  assign O_TA = ta_reg;
  assign O_TEA = tea_reg;

  // address high, address low, then 16-bit data
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      zst_reg <= PBAD_Z_IDLE;
      zcnt_reg <= 4'h0;
    end else begin
      case (zst_reg)
        PBAD_Z_IDLE: begin
          if (busy_reg && hit_zbus && !ta_reg) begin
            zst_reg <= PBAD_Z_ADHI;
          end
        end
        PBAD_Z_ADHI: begin
          zst_reg <= PBAD_Z_ADLO;
        end
        PBAD_Z_ADLO: begin
          zst_reg <= PBAD_Z_DATA;
          zcnt_reg <= ZDATA_CYC - 4'h1;
        end
        PBAD_Z_DATA: begin
          if (zcnt_reg == 4'h0) begin
            zst_reg <= PBAD_Z_DONE;
          end else begin
            zcnt_reg <= zcnt_reg - 4'h1;
          end
        end
        PBAD_Z_DONE: begin
          zst_reg <= PBAD_Z_IDLE;
        end
        default: begin
          zst_reg <= PBAD_Z_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      zad_reg <= 16'h0000;
      zad_oe_reg <= 1'b0;
      zas_n_reg <= 1'b1;
      zds_n_reg <= 1'b1;
    end else begin
      case (zst_reg)
        PBAD_Z_IDLE: begin
          zad_reg <= addr_reg[31:16];
          zad_oe_reg <= busy_reg && hit_zbus && !ta_reg;
          zas_n_reg <= 1'b1;
          zds_n_reg <= 1'b1;
        end
        PBAD_Z_ADHI: begin
          zad_reg <= addr_reg[15:0];
          zad_oe_reg <= 1'b1;
          zas_n_reg <= 1'b0;
          zds_n_reg <= 1'b1;
        end
        PBAD_Z_ADLO: begin
          zad_reg <= wdata_reg[15:0];
          zad_oe_reg <= !rw_reg;
          zas_n_reg <= 1'b1;
          zds_n_reg <= 1'b0;
        end
        PBAD_Z_DATA: begin
          zad_oe_reg <= !rw_reg && (zcnt_reg != 4'h0);
          zds_n_reg <= (zcnt_reg == 4'h0);
        end
        default: begin
          zad_oe_reg <= 1'b0;
          zas_n_reg <= 1'b1;
          zds_n_reg <= 1'b1;
        end
      endcase
    end
  end

  assign O_ZAD = zad_reg;
  assign O_ZAD_OE = zad_oe_reg;
  assign O_ZAS_N = zas_n_reg;
  assign O_ZDS_N = zds_n_reg;
  assign O_ZRW = rw_reg;
endmodule
`default_nettype wire

// ==== pbad_decoder_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module pbad_decoder_monitor #(
  parameter int NUM_WIN = 11
) (
  // Clock, reset and bus requests
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_TS,
  input wire logic [31:0] I_ADDR,
  input wire logic I_RW,
  input wire logic [31:0] I_WDATA,
  input wire logic [19:0] I_MODULE_BASE,
  input wire logic I_TGT_ACK,
  // Design answers
  input wire logic [31:0] O_RDATA,
  input wire logic O_RDATA_OE,
  input wire logic O_TA,
  input wire logic O_TEA,
  input wire logic O_BOOT_SEL,
  input wire logic O_GLUE_SEL,
  input wire logic O_PCI_SEL,
  input wire logic O_PCI_DIRECT_SEL,
  input wire logic [3:0] O_PCI_CMD,
  input wire logic [1:0] O_PCI_DBELL_SEL,
  input wire logic O_ONCHIP_SEL,
  input wire logic O_MODULE_SEL,
  input wire logic O_SDRAM_SEL,
  input wire logic O_SRAM_SEL,
  input wire logic [NUM_WIN-1:0] O_ZWIN_SEL,
  input wire logic [15:0] O_ZAD,
  input wire logic O_ZAD_OE,
  input wire logic O_ZAS_N,
  input wire logic O_ZDS_N
);
  logic bsy_reg;
  logic rw_reg;
  logic [31:0] adr_reg;
  logic [31:0] wd_reg;
  wire take = I_TS && !bsy_reg;
  wire [3:0] rgn = I_ADDR[31:28];
  wire zok = I_ADDR[27:16] == 12'h000 && int'(I_ADDR[15:12]) < NUM_WIN;
  wire bad = rgn == 4'h7 || (rgn == 4'h0 && I_ADDR[27:16] != 12'h000) || (rgn == 4'h4 && I_ADDR[27:25] != 3'h0)
    || (rgn == 4'h1 && I_ADDR[27:12] != 16'h0000) || (rgn == 4'h6 && !zok)
    || (rgn == 4'h5 && I_ADDR[27:12] != 16'h0000);

  // Mirrors the one-transfer-at-a-time rule of the bus
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bsy_reg <= 1'b0;
    end else if (take) begin
      bsy_reg <= 1'b1;
    end else if (O_TA || O_TEA || I_TGT_ACK) begin
      bsy_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (take) begin
      adr_reg <= I_ADDR;
      rw_reg <= I_RW;
      wd_reg <= I_WDATA;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_zaddr;
    O_ZWIN_SEL == (NUM_WIN'(1) << adr_reg[15:12]) && O_ZAD_OE && O_ZAD == adr_reg[31:16]
    ##1 !O_ZAS_N && O_ZAD == adr_reg[15:0];
  endsequence
  sequence s_zdata;
    (O_ZAS_N && !O_ZDS_N && (rw_reg || O_ZAD == wd_reg[15:0]))[*4] ##1 O_ZDS_N && !O_ZAD_OE ##1 O_TA;
  endsequence

  chk_cfg_drive: assert property (
    $rose(I_RST_N) |-> O_RDATA_OE && O_RDATA[7:0] == 8'h09) else $error("config byte missing");
  chk_boot_sel: assert property (
    take && I_ADDR[31:16] == 16'h0000 |=> O_BOOT_SEL && !O_SDRAM_SEL) else $error("boot select");
  chk_bad_tea: assert property (
    take && bad |=> !O_BOOT_SEL && !O_GLUE_SEL && !O_SDRAM_SEL && O_ZWIN_SEL == '0 ##1 O_TEA)
    else $error("reserved access not refused");
  chk_glue_ta: assert property (
    take && rgn == 4'h1 && !bad |=> O_GLUE_SEL ##1 O_TA && !O_GLUE_SEL) else $error("glue access");
  chk_pci_cmd: assert property (
    take && rgn == 4'h2 |=> O_PCI_SEL && O_PCI_CMD == (rw_reg ? 4'h6 : 4'h7)
    && O_PCI_DBELL_SEL == {adr_reg[27:0] == 28'h000_0064, adr_reg[27:0] == 28'h000_0060})
    else $error("pci access");
  chk_onchip_sel: assert property (
    take && rgn == 4'h3 |=> O_ONCHIP_SEL && !O_PCI_SEL) else $error("onchip select");
  chk_module_sel: assert property (
    take && I_ADDR[31:12] == I_MODULE_BASE |=> O_MODULE_SEL) else $error("module select");
  chk_sdram_sel: assert property (
    take && rgn == 4'h4 && !bad |=> O_SDRAM_SEL) else $error("sdram select");
  chk_sram_sel: assert property (
    take && rgn == 4'h5 && I_ADDR[27:12] == 16'h0000 |=> O_SRAM_SEL) else $error("sram select");
  chk_direct_sel: assert property (
    take && I_ADDR[31] |=> O_PCI_DIRECT_SEL && !O_PCI_SEL) else $error("direct pci select");
  chk_zbus_cycle: assert property (
    take && rgn == 4'h6 && zok |=> ##1 s_zaddr ##1 s_zdata) else $error("comm bus cycle");
endmodule
`default_nettype wire

// ==== pbad_decoder_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pbad_decoder_tb_top;
  localparam int NW = 11;
  localparam logic [1:0] K_TA = 2'h0;
  localparam logic [1:0] K_TEA = 2'h1;
  localparam logic [1:0] K_EXT = 2'h2;
  typedef struct packed {logic [1:0] kind; logic chk; logic [31:0] data;} pbad_exp_t;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic I_TS = 1'b0;
  logic I_RW = 1'b0;
  logic [31:0] I_ADDR = 32'h0000_0000;
  logic [31:0] I_WDATA = 32'h0000_0000;
  logic [19:0] I_MODULE_BASE = 20'h3000_0;
  logic [1:0] pdly = 2'h0;
  logic [15:0] zrd = 16'h0000;
  logic I_TGT_ACK, O_RDATA_OE, O_TA, O_TEA, O_BOOT_SEL, O_GLUE_SEL, O_PCI_SEL, O_PCI_DIRECT_SEL;
  logic O_ONCHIP_SEL, O_MODULE_SEL, O_SDRAM_SEL, O_SRAM_SEL, O_ZAD_OE, O_ZAS_N, O_ZDS_N, O_ZRW;
  logic [31:0] O_RDATA, last_rd, v0;
  logic [3:0] O_PCI_CMD;
  logic [1:0] O_PCI_DBELL_SEL;
  logic [NW-1:0] O_ZWIN_SEL;
  logic [15:0] I_ZAD, O_ZAD;
  pbad_exp_t exp_q[$];
  pbad_exp_t note;
  int error_cnt = 0;
  int num_checks = 0;
  int done_cnt = 0;
  int seed_v;
  wire ext_sel = O_BOOT_SEL | O_PCI_SEL | O_PCI_DIRECT_SEL | O_ONCHIP_SEL | O_SDRAM_SEL | O_SRAM_SEL;

  always #4 I_CLK = ~I_CLK;

  pbad_decoder #(.NUM_WIN(NW)) dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_TS(I_TS), .I_ADDR(I_ADDR),
    .I_RW(I_RW), .I_WDATA(I_WDATA), .I_MODULE_BASE(I_MODULE_BASE), .I_TGT_ACK(I_TGT_ACK),
    .O_RDATA(O_RDATA), .O_RDATA_OE(O_RDATA_OE), .O_TA(O_TA), .O_TEA(O_TEA), .O_BOOT_SEL(O_BOOT_SEL),
    .O_GLUE_SEL(O_GLUE_SEL), .O_PCI_SEL(O_PCI_SEL), .O_PCI_DIRECT_SEL(O_PCI_DIRECT_SEL),
    .O_PCI_CMD(O_PCI_CMD), .O_PCI_DBELL_SEL(O_PCI_DBELL_SEL), .O_ONCHIP_SEL(O_ONCHIP_SEL),
    .O_MODULE_SEL(O_MODULE_SEL), .O_SDRAM_SEL(O_SDRAM_SEL), .O_SRAM_SEL(O_SRAM_SEL),
    .O_ZWIN_SEL(O_ZWIN_SEL), .I_ZAD(I_ZAD), .O_ZAD(O_ZAD), .O_ZAD_OE(O_ZAD_OE), .O_ZAS_N(O_ZAS_N),
    .O_ZDS_N(O_ZDS_N), .O_ZRW(O_ZRW));

  pbad_target_model u_tgt (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ext_sel(ext_sel), .i_dly(pdly),
    .i_rd_val(zrd), .i_zad_oe(O_ZAD_OE), .i_zds_n(O_ZDS_N), .o_ack(I_TGT_ACK), .o_zad(I_ZAD));

  task automatic check_val(input string name, input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic finish_test();
    check_val("pending notes", exp_q.size(), 32'h0000_0000);
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic acc(input logic [31:0] a, input logic rw, input logic [1:0] k, input logic chk,
    input logic [31:0] d);
    int base;
    int n;
    base = done_cnt;
    n = 0;
    @(posedge I_CLK);
    #1;
    zrd = 16'($urandom);
    pdly = 2'($urandom_range(3));
    if (a[31:28] == 4'h6) begin
      d = {16'h0000, zrd};
    end
    exp_q.push_back('{k, chk, d});
    I_TS = 1'b1;
    I_ADDR = a;
    I_RW = rw;
    I_WDATA = $urandom;
    @(posedge I_CLK);
    #1;
    I_TS = 1'b0;
    while (done_cnt == base && n < 40) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    check_val("answered", n < 40, 32'h0000_0001);
  endtask

  always @(posedge I_CLK) begin
    if (I_RST_N && (O_TA || O_TEA || I_TGT_ACK)) begin
      note.kind = 2'h3;
      if (exp_q.size() > 0) begin
        note = exp_q.pop_front();
      end
      check_val("response", {30'h0, I_TGT_ACK, O_TEA}, {30'h0, note.kind});
      check_val("read drive", {30'h0, O_RDATA_OE, O_ZRW}, {30'h0, (note.kind == K_TA && I_RW), I_RW});
      if (note.chk) begin
        check_val("read data", O_RDATA, note.data);
      end
      last_rd = O_RDATA;
      done_cnt++;
    end
  end

  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end

  initial begin
    seed_v = $urandom(9247);
    repeat (4) @(posedge I_CLK);
    #1;
    I_RST_N = 1'b1;
    acc(32'h0000_1234, 1'b1, K_EXT, 1'b0, 32'h0);
    acc(32'h0001_0000, 1'b1, K_TEA, 1'b0, 32'h0);
    acc(32'h1000_0008, 1'b1, K_TA, 1'b1, 32'h0);
    acc(32'h1000_0000, 1'b0, K_TA, 1'b0, 32'h0);
    acc(32'h1000_1000, 1'b1, K_TEA, 1'b0, 32'h0);
    acc(32'h2000_0060, 1'b1, K_EXT, 1'b0, 32'h0);
    acc(32'h2000_0064, 1'b0, K_EXT, 1'b0, 32'h0);
    acc(32'h3000_0248, 1'b1, K_EXT, 1'b0, 32'h0);
    I_MODULE_BASE = 20'h3000_1;
    acc(32'h3000_1004, 1'b0, K_EXT, 1'b0, 32'h0);
    acc(32'h41ff_fffc, 1'b0, K_EXT, 1'b0, 32'h0);
    acc(32'h4200_0000, 1'b1, K_TEA, 1'b0, 32'h0);
    acc(32'h5000_0ffc, 1'b1, K_EXT, 1'b0, 32'h0);
    acc(32'h7000_0000, 1'b0, K_TEA, 1'b0, 32'h0);
    acc(32'h8000_0000, 1'b1, K_EXT, 1'b0, 32'h0);
    acc(32'hffff_fff0, 1'b0, K_EXT, 1'b0, 32'h0);
    for (int i = 0; i < NW; i++) begin
      acc({16'h6000, 4'(i), 12'h000}, i[0], K_TA, i[0], 32'h0);
    end
    acc(32'h6000_b000, 1'b1, K_TEA, 1'b0, 32'h0);
    acc(32'h1000_0004, 1'b1, K_TA, 1'b1, 32'h6000_b000);
    acc(32'h1000_0000, 1'b1, K_TA, 1'b0, 32'h0);
    v0 = last_rd;
    // Two samples exactly 250 cycles (2 us) apart
    repeat (246) @(posedge I_CLK);
    acc(32'h1000_0000, 1'b1, K_TA, 1'b0, 32'h0);
    check_val("usec delta", last_rd - v0, 32'h0000_0002);
    finish_test();
  end
endmodule

bind pbad_decoder pbad_decoder_monitor #(.NUM_WIN(NUM_WIN)) u_mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_TS(I_TS), .I_ADDR(I_ADDR), .I_RW(I_RW), .I_WDATA(I_WDATA), .I_MODULE_BASE(I_MODULE_BASE),
  .I_TGT_ACK(I_TGT_ACK), .O_RDATA(O_RDATA), .O_RDATA_OE(O_RDATA_OE), .O_TA(O_TA), .O_TEA(O_TEA),
  .O_BOOT_SEL(O_BOOT_SEL), .O_GLUE_SEL(O_GLUE_SEL), .O_PCI_SEL(O_PCI_SEL), .O_PCI_DIRECT_SEL(O_PCI_DIRECT_SEL),
  .O_PCI_CMD(O_PCI_CMD), .O_PCI_DBELL_SEL(O_PCI_DBELL_SEL), .O_ONCHIP_SEL(O_ONCHIP_SEL),
  .O_MODULE_SEL(O_MODULE_SEL), .O_SDRAM_SEL(O_SDRAM_SEL), .O_SRAM_SEL(O_SRAM_SEL),
  .O_ZWIN_SEL(O_ZWIN_SEL), .O_ZAD(O_ZAD), .O_ZAD_OE(O_ZAD_OE), .O_ZAS_N(O_ZAS_N), .O_ZDS_N(O_ZDS_N));
`default_nettype wire

// ==== pbad_pkg.sv ====
package pbad_pkg;
  typedef enum logic [4:0] {
    PBAD_Z_IDLE = 5'b0_0001,
    PBAD_Z_ADHI = 5'b0_0010,
    PBAD_Z_ADLO = 5'b0_0100,
    PBAD_Z_DATA = 5'b0_1000,
    PBAD_Z_DONE = 5'b1_0000
  } pbad_zstate_t;
endpackage

// ==== pbad_target_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module pbad_target_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Target side of the bus
  input wire logic i_ext_sel,
  input wire logic [1:0] i_dly,
  input wire logic [15:0] i_rd_val,
  input wire logic i_zad_oe,
  input wire logic i_zds_n,
  output logic o_ack,
  output logic [15:0] o_zad
);
  logic [1:0] cnt_reg;
  logic [15:0] idle_reg;

  // Only a selected target ends a transfer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'h0;
      o_ack <= 1'b0;
    end else if (!i_ext_sel || o_ack) begin
      cnt_reg <= 2'h0;
      o_ack <= 1'b0;
    end else if (cnt_reg == i_dly) begin
      o_ack <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // Released lines show the inverse of their last value, so a stale sample shows up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_reg <= 16'h0000;
    end else begin
      idle_reg <= ~o_zad;
    end
  end

  // Device drives the data phase of a read only
  assign o_zad = (!i_zds_n && !i_zad_oe) ? i_rd_val : idle_reg;
endmodule
`default_nettype wire

// ==== pbad_usec_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pbad_cfg.svh"
module pbad_usec_counter
  import pbad_pkg::*;
#(
  parameter int DIV = `PBAD_USEC_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  pbad_cnt_if.counter cnt
);
  logic [7:0] pre_reg;
  logic [31:0] count_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reg <= 8'h00;
    end else if (pre_reg == 8'(DIV - 1)) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 32'h0000_0000;
    end else if (pre_reg == 8'(DIV - 1)) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  assign cnt.count = count_reg;
  assign cnt.tick = (pre_reg == 8'(DIV - 1));
endmodule
`default_nettype wire
